// >>> hdl/atm_defs.svh
// constants for the arbitrary waveform trigger and marker control block
`ifndef ATM_DEFS_SVH
`define ATM_DEFS_SVH

`define ATM_CLK_PERIOD_NS 5'd8
`define ATM_TICK_NS 5'd10
`define ATM_TMR_W 30
`define ATM_SEG_W 8
`define ATM_MK_N 4
`define ATM_MK_DLY_W 20
`define ATM_MK_LIST_W 32
`define ATM_DR_MAX_DEF 20'h00fff
`define ATM_DR_MIN_DEF 20'h00000

`define ATM_OFF_CTRL 8'h00
`define ATM_OFF_CMD 8'h04
`define ATM_OFF_TDLY 8'h08
`define ATM_OFF_TINH 8'h0c
`define ATM_OFF_SEGCUR 8'h10
`define ATM_OFF_SEGNXT 8'h14
`define ATM_OFF_DRMAX 8'h18
`define ATM_OFF_DRMIN 8'h1c
`define ATM_OFF_STS 8'h20
`define ATM_OFF_CLR 8'h24
`define ATM_OFF_IEN 8'h28
`define ATM_OFF_MKDLY 4'h4
`define ATM_OFF_MKMODE 4'h5
`define ATM_OFF_MKLIST 4'h6

`define ATM_CTRL_SRC_LSB 0
`define ATM_CTRL_EDGE_BIT 2
`define ATM_CTRL_MAUTO_BIT 3
`define ATM_CTRL_SEQ_LSB 4
`define ATM_CTRL_LOCK_BIT 6
`define ATM_CMD_MAN_BIT 0
`define ATM_CMD_BUS_BIT 1
`define ATM_STS_TRIG_BIT 0
`define ATM_STS_RANGE_BIT 1
`define ATM_STS_SER_BIT 2

`define ATM_RST_CTRL 32'h0000_0007
`endif

// >>> hdl/atm_pkg.sv
// types of the trigger and marker control block
`default_nettype none
`include "atm_defs.svh"
package atm_pkg;
	typedef enum logic [1:0] {
		SRC_MANUAL = 2'h0,
		SRC_EXTERNAL = 2'h1,
		SRC_BUS = 2'h2,
		SRC_AUTO = 2'h3
	} atm_src_type;
	typedef enum logic [1:0] {
		SEQ_AUTO_STEP = 2'h0,
		SEQ_HOP_PARALLEL = 2'h1,
		SEQ_HOP_SERIAL = 2'h2
	} atm_seq_type;
	typedef enum logic [2:0] {
		MK_WAVEFORM = 3'h0,
		MK_RESTART = 3'h1,
		MK_PULSE = 3'h2,
		MK_PATTERN = 3'h3,
		MK_ON_OFF = 3'h4,
		MK_LIST = 3'h5
	} atm_mk_mode_type;
	typedef struct packed {
		logic [`ATM_TMR_W-1:0] cnt;
		logic done;
	} atm_tmr_state_type;
	typedef struct packed {
		logic [`ATM_MK_DLY_W:0] pos;
		logic run;
		logic out;
	} atm_mk_state_type;
	typedef struct packed {
		logic ack;
		logic [31:0] rdat;
		atm_src_type src;
		logic edge_rise;
		logic mode_auto;
		atm_seq_type seq;
		logic lock;
		logic [`ATM_TMR_W-1:0] dly;
		logic [`ATM_TMR_W-1:0] inh;
		logic [`ATM_SEG_W-1:0] seg_cur;
		logic [`ATM_SEG_W-1:0] seg_next;
		logic [2:0] sts;
		logic [2:0] ien;
		logic irq;
		logic [`ATM_MK_N-1:0][`ATM_MK_DLY_W-1:0] mk_dly;
		logic [`ATM_MK_N-1:0][2:0] mk_mode;
		logic [`ATM_MK_N-1:0][`ATM_MK_LIST_W-1:0] mk_list;
		logic ext_prev;
		logic auto_done;
		logic trig;
		logic [4:0] tick_acc;
		logic tick;
		logic [`ATM_SEG_W-1:0] ser_sh;
		logic ser_prev;
	} atm_top_state_type;
endpackage
`default_nettype wire

// >>> hdl/atm_if.sv
// links between the control core and its timers and marker channels
`default_nettype none
`include "atm_defs.svh"
interface atm_tmr_if;
	logic load;
	logic [`ATM_TMR_W-1:0] value;
	logic tick;
	logic busy;
	logic done;
	modport ctl (output load, output value, output tick, input busy, input done);
	modport tmr (input load, input value, input tick, output busy, output done);
endinterface

interface atm_mk_if;
	logic start;
	logic wave_bit;
	logic [`ATM_MK_DLY_W-1:0] delay;
	logic [2:0] mode;
	logic [`ATM_MK_LIST_W-1:0] list;
	logic out;
	modport ctl (output start, output wave_bit, output delay, output mode, output list, input out);
	modport mk (input start, input wave_bit, input delay, input mode, input list, output out);
endinterface
`default_nettype wire

// >>> hdl/atm_timer.sv
// 10 ns down-counter used for trigger delay and restart inhibit
`default_nettype none
`include "atm_defs.svh"
module atm_timer
(
	input wire logic i_clk,
	input wire logic i_resetn,
	atm_tmr_if.tmr tmr
);
	atm_pkg::atm_tmr_state_type st_reg;
	atm_pkg::atm_tmr_state_type st_next;

	assign tmr.busy = (st_reg.cnt != '0);
	assign tmr.done = st_reg.done;

	always_comb
	begin
		st_next = st_reg;
		st_next.done = 1'b0;
		if (tmr.load)
		begin
			st_next.cnt = tmr.value;
		end
		else if (tmr.tick && st_reg.cnt != '0)
		begin
			st_next.cnt = st_reg.cnt - 1'b1;
			st_next.done = (st_reg.cnt == `ATM_TMR_W'(1));
		end
	end

	always_ff @(posedge i_clk or negedge i_resetn)
	begin
		if (!i_resetn)
			st_reg <= '0;
		else
			st_reg <= st_next;
	end
endmodule
`default_nettype wire

// >>> hdl/atm_marker.sv
// one marker output channel: delay from signal start and mode generation
`default_nettype none
`include "atm_defs.svh"
module atm_marker
(
	input wire logic i_clk,
	input wire logic i_resetn,
	atm_mk_if.mk mk
);
	atm_pkg::atm_mk_state_type st_reg;
	atm_pkg::atm_mk_state_type st_next;
	logic active;
	logic [`ATM_MK_DLY_W:0] rel;

	assign mk.out = st_reg.out;

	always_comb
	begin
		st_next = st_reg;
		active = st_reg.run && (st_reg.pos >= {1'b0, mk.delay});
		rel = st_reg.pos - {1'b0, mk.delay};
		if (mk.start)
		begin
			st_next.pos = '0;
			st_next.run = 1'b1;
		end
		else if (st_reg.run && st_reg.pos != '1)
			st_next.pos = st_reg.pos + 1'b1;
		case (atm_pkg::atm_mk_mode_type'(mk.mode))
			atm_pkg::MK_WAVEFORM: st_next.out = mk.wave_bit;
			atm_pkg::MK_RESTART: st_next.out = st_reg.run && (st_reg.pos == {1'b0, mk.delay});
			atm_pkg::MK_PULSE: st_next.out = active && rel[0];
			atm_pkg::MK_PATTERN: st_next.out = active && mk.list[rel[4:0]];
			atm_pkg::MK_ON_OFF: st_next.out = active && !rel[0];
			atm_pkg::MK_LIST: st_next.out = active && (rel < `ATM_MK_LIST_W) && mk.list[rel[4:0]];
			default: st_next.out = 1'b0;
		endcase
	end

	always_ff @(posedge i_clk or negedge i_resetn)
	begin
		if (!i_resetn)
			st_reg <= '0;
		else
			st_reg <= st_next;
	end
endmodule
`default_nettype wire

// >>> hdl/atm_top.sv
// trigger source, segment sequencing and marker control with wishbone registers
`default_nettype none
`include "atm_defs.svh"
module atm_top
#(
	parameter logic [`ATM_MK_DLY_W-1:0] DR_MAX = `ATM_DR_MAX_DEF,
	parameter logic [`ATM_MK_DLY_W-1:0] DR_MIN = `ATM_DR_MIN_DEF
)
(
	input wire logic i_clk,
	input wire logic i_resetn,
	input wire logic i_wb_cyc,
	input wire logic i_wb_stb,
	input wire logic i_wb_we,
	input wire logic [7:0] i_wb_adr,
	input wire logic [3:0] i_wb_sel,
	input wire logic [31:0] i_wb_dat,
	output logic [31:0] o_wb_dat,
	output logic o_wb_ack,
	input wire logic i_ext_trigger,
	input wire logic [`ATM_SEG_W-1:0] i_hop_parallel_index,
	input wire logic i_hop_serial_frame,
	input wire logic i_hop_serial_data,
	input wire logic [`ATM_MK_N-1:0] i_waveform_defined_marker,
	output logic o_trigger,
	output logic [`ATM_SEG_W-1:0] o_current_segment_index,
	output logic [`ATM_MK_N-1:0] o_marker,
	output logic o_irq
);
	atm_pkg::atm_top_state_type st_reg;
	atm_pkg::atm_top_state_type st_next;
	atm_tmr_if dly_if ();
	atm_tmr_if inh_if ();
	atm_mk_if mk_if [`ATM_MK_N] ();
	logic [`ATM_MK_N-1:0] mk_out;

	logic req;
	logic wr;
	logic [31:0] wmask;
	logic [31:0] wval;
	logic ext_edge;
	logic ext_ok;
	logic ext_fire;
	logic fire;
	logic [`ATM_SEG_W-1:0] seg_take;
	logic [2:0] sts_set;
	logic [2:0] sts_clr;
	logic [4:0] acc_sum;
	logic [1:0] mk_idx;
	logic [3:0] page;

	assign o_wb_dat = st_reg.rdat;
	assign o_wb_ack = st_reg.ack;
	assign o_trigger = st_reg.trig;
	assign o_current_segment_index = st_reg.seg_cur;
	assign o_irq = st_reg.irq;
	assign o_marker = mk_out;

	atm_timer u_dly
	(
		.i_clk(i_clk),
		.i_resetn(i_resetn),
		.tmr(dly_if)
	);

	atm_timer u_inh
	(
		.i_clk(i_clk),
		.i_resetn(i_resetn),
		.tmr(inh_if)
	);

	genvar g;
	generate
		for (g = 0; g < `ATM_MK_N; g++)
		begin : g_mk
			assign mk_if[g].start = st_reg.trig;
			assign mk_if[g].wave_bit = i_waveform_defined_marker[g];
			assign mk_if[g].delay = st_reg.mk_dly[g];
			assign mk_if[g].mode = st_reg.mk_mode[g];
			assign mk_if[g].list = st_reg.mk_list[g];
			assign mk_out[g] = mk_if[g].out;
			atm_marker u_mk
			(
				.i_clk(i_clk),
				.i_resetn(i_resetn),
				.mk(mk_if[g])
			);
		end
	endgenerate

	// external edge path: inhibit, then delay
	always_comb
	begin
		ext_edge = st_reg.edge_rise ? (i_ext_trigger && !st_reg.ext_prev)
			: (!i_ext_trigger && st_reg.ext_prev);
		ext_ok = (st_reg.src == atm_pkg::SRC_EXTERNAL) && ext_edge
			&& !inh_if.busy && !dly_if.busy;
		ext_fire = (ext_ok && st_reg.dly == '0) || dly_if.done;
		dly_if.load = ext_ok && st_reg.dly != '0;
		dly_if.value = st_reg.dly;
		dly_if.tick = st_reg.tick;
		inh_if.load = ext_fire;
		inh_if.value = st_reg.inh;
		inh_if.tick = st_reg.tick;
	end

	always_comb
	begin
		st_next = st_reg;
		req = i_wb_cyc && i_wb_stb && !st_reg.ack;
		wr = req && i_wb_we;
		wmask = {{8{i_wb_sel[3]}}, {8{i_wb_sel[2]}}, {8{i_wb_sel[1]}}, {8{i_wb_sel[0]}}};
		wval = i_wb_dat & wmask;
		page = i_wb_adr[7:4];
		mk_idx = i_wb_adr[3:2];
		sts_set = '0;
		sts_clr = '0;
		fire = 1'b0;
		seg_take = st_reg.seg_next;

		// 10 ns tick from the 8 ns clock by remainder accumulation
		acc_sum = st_reg.tick_acc + `ATM_CLK_PERIOD_NS;
		st_next.tick = (acc_sum >= `ATM_TICK_NS);
		st_next.tick_acc = st_next.tick ? acc_sum - `ATM_TICK_NS : acc_sum;

		st_next.ext_prev = i_ext_trigger;
		if (ext_fire)
			fire = 1'b1;
		if (st_reg.src == atm_pkg::SRC_AUTO)
		begin
			if (!st_reg.auto_done)
				fire = 1'b1;
			st_next.auto_done = 1'b1;
		end
		else
			st_next.auto_done = 1'b0;
		if (wr && i_wb_adr == `ATM_OFF_CMD && i_wb_sel[0])
		begin
			if (i_wb_dat[`ATM_CMD_MAN_BIT] && st_reg.src == atm_pkg::SRC_MANUAL && !st_reg.mode_auto)
				fire = 1'b1;
			if (i_wb_dat[`ATM_CMD_BUS_BIT] && st_reg.src == atm_pkg::SRC_BUS)
				fire = 1'b1;
		end

		// serial hopping: shift while framed, msb first, take on frame end
		st_next.ser_prev = i_hop_serial_frame;
		if (i_hop_serial_frame)
			st_next.ser_sh = {st_reg.ser_sh[`ATM_SEG_W-2:0], i_hop_serial_data};
		if (st_reg.ser_prev && !i_hop_serial_frame && st_reg.seq == atm_pkg::SEQ_HOP_SERIAL)
		begin
			st_next.seg_next = st_reg.ser_sh;
			sts_set[`ATM_STS_SER_BIT] = 1'b1;
		end

		// segment switch on trigger
		st_next.trig = fire;
		if (fire)
		begin
			if (st_reg.seq == atm_pkg::SEQ_HOP_PARALLEL)
				seg_take = i_hop_parallel_index;
			st_next.seg_cur = seg_take;
			if (st_reg.seq == atm_pkg::SEQ_AUTO_STEP)
				st_next.seg_next = `ATM_SEG_W'(seg_take + 1'b1);
			sts_set[`ATM_STS_TRIG_BIT] = 1'b1;
		end

		// register writes
		if (wr)
		begin
			case (i_wb_adr)
				`ATM_OFF_CTRL:
				begin
					if (i_wb_sel[0])
					begin
						st_next.src = atm_pkg::atm_src_type'(i_wb_dat[`ATM_CTRL_SRC_LSB +: 2]);
						st_next.edge_rise = i_wb_dat[`ATM_CTRL_EDGE_BIT];
						st_next.mode_auto = i_wb_dat[`ATM_CTRL_MAUTO_BIT];
						st_next.seq = atm_pkg::atm_seq_type'(i_wb_dat[`ATM_CTRL_SEQ_LSB +: 2]);
						st_next.lock = i_wb_dat[`ATM_CTRL_LOCK_BIT];
					end
				end
				`ATM_OFF_TDLY:
				begin
					if (st_reg.src == atm_pkg::SRC_EXTERNAL)
						st_next.dly = `ATM_TMR_W'((st_reg.dly & ~wmask[`ATM_TMR_W-1:0]) | wval);
				end
				`ATM_OFF_TINH:
					st_next.inh = `ATM_TMR_W'((st_reg.inh & ~wmask[`ATM_TMR_W-1:0]) | wval);
				`ATM_OFF_SEGNXT:
					st_next.seg_next = `ATM_SEG_W'((st_reg.seg_next & ~wmask[`ATM_SEG_W-1:0]) | wval);
				`ATM_OFF_CLR:
					sts_clr = wval[2:0];
				`ATM_OFF_IEN:
					st_next.ien = wval[2:0] | (st_reg.ien & ~wmask[2:0]);
				default:
				begin
					if (page == `ATM_OFF_MKDLY)
					begin
						st_next.mk_dly[mk_idx] = `ATM_MK_DLY_W'((st_reg.mk_dly[mk_idx]
							& ~wmask[`ATM_MK_DLY_W-1:0]) | wval);
						if (st_reg.lock && (st_next.mk_dly[mk_idx] > DR_MAX
							|| st_next.mk_dly[mk_idx] < DR_MIN))
						begin
							st_next.mk_dly[mk_idx] = DR_MAX;
							sts_set[`ATM_STS_RANGE_BIT] = 1'b1;
						end
					end
					else if (page == `ATM_OFF_MKMODE)
					begin
						if (i_wb_sel[0])
							st_next.mk_mode[mk_idx] = i_wb_dat[2:0];
					end
					else if (page == `ATM_OFF_MKLIST)
						st_next.mk_list[mk_idx] = (st_reg.mk_list[mk_idx] & ~wmask) | wval;
				end
			endcase
		end

		// sticky status, set wins over clear
		st_next.sts = (st_reg.sts & ~sts_clr) | sts_set;
		st_next.irq = |(st_next.sts & st_next.ien);

		// bus answer: one cycle after request, unmapped reads zero
		st_next.ack = req;
		st_next.rdat = '0;
		if (req && !i_wb_we)
		begin
			case (i_wb_adr)
				`ATM_OFF_CTRL:
					st_next.rdat = 32'({st_reg.lock, st_reg.seq, st_reg.mode_auto, st_reg.edge_rise, st_reg.src});
				`ATM_OFF_TDLY: st_next.rdat = 32'(st_reg.dly);
				`ATM_OFF_TINH: st_next.rdat = 32'(st_reg.inh);
				`ATM_OFF_SEGCUR: st_next.rdat = 32'(st_reg.seg_cur);
				`ATM_OFF_SEGNXT: st_next.rdat = 32'(st_reg.seg_next);
				`ATM_OFF_DRMAX: st_next.rdat = 32'(DR_MAX);
				`ATM_OFF_DRMIN: st_next.rdat = 32'(DR_MIN);
				`ATM_OFF_STS: st_next.rdat = 32'(st_reg.sts);
				`ATM_OFF_IEN: st_next.rdat = 32'(st_reg.ien);
				default:
				begin
					if (page == `ATM_OFF_MKDLY)
						st_next.rdat = 32'(st_reg.mk_dly[mk_idx]);
					else if (page == `ATM_OFF_MKMODE)
						st_next.rdat = 32'(st_reg.mk_mode[mk_idx]);
					else if (page == `ATM_OFF_MKLIST)
						st_next.rdat = st_reg.mk_list[mk_idx];
				end
			endcase
		end
	end

	always_ff @(posedge i_clk or negedge i_resetn)
	begin
		if (!i_resetn)
		begin
			st_reg <= '0;
			st_reg.src <= atm_pkg::SRC_AUTO;
			st_reg.edge_rise <= 1'b1;
			st_reg.seq <= atm_pkg::SEQ_AUTO_STEP;
		end
		else
			st_reg <= st_next;
	end
endmodule
`default_nettype wire

// >>> dv/atm_top_sva.sv
// assertion checker on the trigger and marker top ports
`default_nettype none
`include "atm_defs.svh"
module atm_top_sva
#(
	parameter logic [`ATM_MK_DLY_W-1:0] DR_MAX = `ATM_DR_MAX_DEF,
	parameter logic [`ATM_MK_DLY_W-1:0] DR_MIN = `ATM_DR_MIN_DEF
)
(
	input wire logic i_clk,
	input wire logic i_resetn,
	input wire logic i_wb_cyc,
	input wire logic i_wb_stb,
	input wire logic i_wb_we,
	input wire logic [7:0] i_wb_adr,
	input wire logic [3:0] i_wb_sel,
	input wire logic [31:0] i_wb_dat,
	input wire logic [31:0] o_wb_dat,
	input wire logic o_wb_ack,
	input wire logic o_trigger,
	input wire logic [7:0] o_current_segment_index
);
	logic tk;
	logic rq;
	logic wq;
	logic [1:0] src_reg;
	logic mauto_reg;
	assign tk = i_wb_cyc && i_wb_stb && !o_wb_ack;
	assign rq = tk && !i_wb_we;
	assign wq = tk && i_wb_we && i_wb_sel[0];
	// mirror of source select and manual refusal bit
	always_ff @(posedge i_clk or negedge i_resetn)
	begin
		if (!i_resetn)
		begin
			src_reg <= 2'h3;
			mauto_reg <= 1'b0;
		end
		else if (wq && i_wb_adr == 8'h00)
		begin
			src_reg <= i_wb_dat[1:0];
			mauto_reg <= i_wb_dat[3];
		end
	end
	default clocking @(posedge i_clk);
	endclocking
	default disable iff (!i_resetn);
	property p_ack; tk |=> o_wb_ack ##1 !o_wb_ack; endproperty
	a_ack: assert property (p_ack) else $error("ack not one pulse");
	property p_rst; $rose(i_resetn) |-> ##[0:3] o_trigger; endproperty
	a_rst: assert property (p_rst) else $error("no trigger after reset");
	property p_seg; !o_trigger |-> $stable(o_current_segment_index); endproperty
	a_seg: assert property (p_seg) else $error("segment moved without trigger");
	property p_bus; wq && i_wb_adr == 8'h04 && i_wb_dat[1] && src_reg == 2'h2 |=> o_trigger; endproperty
	a_bus: assert property (p_bus) else $error("bus command gave no trigger");
	property p_man;
		wq && i_wb_adr == 8'h04 && i_wb_dat[1:0] == 2'h1 && src_reg == 2'h0 |=> o_trigger != $past(mauto_reg);
	endproperty
	a_man: assert property (p_man) else $error("manual trigger wrong");
	property p_dmax; rq && i_wb_adr == 8'h18 |=> o_wb_dat == {12'h0, DR_MAX}; endproperty
	a_dmax: assert property (p_dmax) else $error("range max wrong");
	property p_dmin; rq && i_wb_adr == 8'h1c |=> o_wb_dat == {12'h0, DR_MIN}; endproperty
	a_dmin: assert property (p_dmin) else $error("range min wrong");
	property p_cur; rq && i_wb_adr == 8'h10 |=> o_wb_dat == {24'h0, $past(o_current_segment_index)}; endproperty
	a_cur: assert property (p_cur) else $error("segment read wrong");
endmodule
`default_nettype wire

// >>> dv/atm_src_model.sv
// far side model: external trigger line and segment hopping inputs
`default_nettype none
`include "atm_defs.svh"
module atm_src_model
(
	input wire logic i_clk,
	output logic o_ext_trigger,
	output logic [7:0] o_hop_parallel_index,
	output logic o_hop_serial_frame,
	output logic o_hop_serial_data
);
	timeunit 1ns;
	timeprecision 1ps;
	initial
	begin
		o_ext_trigger = 1'b0;
		o_hop_parallel_index = 8'h00;
		o_hop_serial_frame = 1'b0;
		o_hop_serial_data = 1'b0;
	end
	task automatic pulse(input int len);
		@(posedge i_clk);
		o_ext_trigger <= 1'b1;
		repeat (len) @(posedge i_clk);
		o_ext_trigger <= 1'b0;
	endtask
	task automatic put_index(input logic [7:0] idx);
		@(posedge i_clk);
		o_hop_parallel_index <= idx;
	endtask
	task automatic send_serial(input logic [7:0] idx);
		for (int k = 7; k >= 0; k--)
		begin
			@(posedge i_clk);
			o_hop_serial_frame <= 1'b1;
			o_hop_serial_data <= idx[k];
		end
		@(posedge i_clk);
		o_hop_serial_frame <= 1'b0;
		// released line must not keep the last bit
		o_hop_serial_data <= ~idx[0];
	endtask
endmodule
`default_nettype wire

// >>> dv/atm_top_bench.sv
// self-checking bench of the trigger and marker top
`default_nettype none
`include "atm_defs.svh"
module atm_top_bench;
	timeunit 1ns;
	timeprecision 1ps;
	logic clk = 1'b0;
	logic resetn = 1'b0;
	logic cyc = 1'b0;
	logic stb = 1'b0;
	logic we = 1'b0;
	logic [7:0] adr = 8'h00;
	logic [3:0] sel = 4'hf;
	logic [31:0] wdat = 32'h0;
	logic [3:0] wmk = 4'h0;
	logic [31:0] rdat;
	logic [7:0] pidx, seg;
	logic [3:0] mk;
	logic ack, ext, sfr, sdat, trig, irq;
	int mismatches = 0;
	int cmp_count = 0;
	int at;
	always #4 clk = ~clk;
	atm_top atm_top_i (.i_clk(clk), .i_resetn(resetn), .i_wb_cyc(cyc), .i_wb_stb(stb), .i_wb_we(we),
		.i_wb_adr(adr), .i_wb_sel(sel), .i_wb_dat(wdat), .o_wb_dat(rdat), .o_wb_ack(ack), .i_ext_trigger(ext),
		.i_hop_parallel_index(pidx), .i_hop_serial_frame(sfr), .i_hop_serial_data(sdat),
		.i_waveform_defined_marker(wmk), .o_trigger(trig), .o_current_segment_index(seg), .o_marker(mk), .o_irq(irq));
	atm_src_model atm_src_model_i (.i_clk(clk), .o_ext_trigger(ext), .o_hop_parallel_index(pidx),
		.o_hop_serial_frame(sfr), .o_hop_serial_data(sdat));
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		cmp_count++;
		if (seen !== exp)
		begin
			mismatches++;
			$display("CHECK FAILED at %0t: saw %h wanted %h", $time, seen, exp);
		end
	endtask
	task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q);
		int n;
		n = 0;
		cyc <= 1'b1;
		stb <= 1'b1;
		we <= w;
		adr <= a;
		wdat <= d;
		do
		begin
			@(posedge clk);
			n++;
		end
		while (ack !== 1'b1 && n < 20);
		q = rdat;
		cyc <= 1'b0;
		stb <= 1'b0;
		@(posedge clk);
		check(32'(n < 20), 32'h1);
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		logic [31:0] q;
		wb(1'b1, a, d, q);
	endtask
	task automatic rd(input logic [7:0] a, input logic [31:0] e);
		logic [31:0] q;
		wb(1'b0, a, 32'h0, q);
		check(q, e);
	endtask
	task automatic first_trig(input int span);
		at = -1;
		for (int n = 1; n <= span; n++)
		begin
			@(posedge clk);
			if (trig === 1'b1 && at < 0)
				at = n;
		end
	endtask
	task automatic ext_fire(input int lo, input int hi);
		fork
			atm_src_model_i.pulse(3);
			first_trig(20);
		join
		check(32'(at >= lo && at <= hi), 32'h1);
	endtask
	task automatic t_reset;
		rd(8'h00, 32'h7);
		rd(8'h10, 32'h0);
		rd(8'h14, 32'h1);
		rd(8'h20, 32'h1);
		wr(8'h08, 32'h5);
		rd(8'h08, 32'h0);
		rd(8'h40, 32'h0);
		rd(8'hfc, 32'h0);
	endtask
	task automatic t_bus_irq;
		wr(8'h00, 32'h6);
		wr(8'h24, 32'h7);
		wr(8'h28, 32'h1);
		check(32'(irq), 32'h0);
		wr(8'h14, 32'h5);
		wr(8'h04, 32'h2);
		check(32'(irq), 32'h1);
		rd(8'h10, 32'h5);
		rd(8'h14, 32'h6);
		wr(8'h28, 32'h0);
		check(32'(irq), 32'h0);
		wr(8'h28, 32'h1);
		wr(8'h24, 32'h1);
		check(32'(irq), 32'h0);
	endtask
	task automatic t_manual;
		wr(8'h00, 32'h8);
		wr(8'h04, 32'h1);
		rd(8'h10, 32'h5);
		sel <= 4'h0;
		wr(8'h00, 32'h0);
		sel <= 4'hf;
		rd(8'h00, 32'h8);
		wr(8'h00, 32'h0);
		wr(8'h04, 32'h1);
		rd(8'h10, 32'h6);
	endtask
	task automatic t_ext;
		wr(8'h00, 32'h1);
		ext_fire(6, 7);
		wr(8'h00, 32'h5);
		wr(8'h08, 32'h8);
		ext_fire(12, 16);
		wr(8'h08, 32'h0);
		wr(8'h0c, 32'h28);
		ext_fire(3, 4);
		ext_fire(-1, -1);
		repeat (60) @(posedge clk);
		ext_fire(3, 4);
		wr(8'h0c, 32'h0);
	endtask
	task automatic t_hop;
		wr(8'h00, 32'h16);
		atm_src_model_i.put_index(8'h2a);
		wr(8'h04, 32'h2);
		rd(8'h10, 32'h2a);
		wr(8'h00, 32'h26);
		wr(8'h24, 32'h7);
		atm_src_model_i.send_serial(8'h93);
		repeat (2) @(posedge clk);
		rd(8'h14, 32'h93);
		rd(8'h20, 32'h4);
		wr(8'h04, 32'h2);
		rd(8'h10, 32'h93);
	endtask
	task automatic t_marker;
		int hi0, hi1, hi2, f0, ft;
		hi0 = 0;
		hi1 = 0;
		hi2 = 0;
		f0 = -1;
		ft = -1;
		for (int m = 0; m < 6; m++)
		begin
			wr(8'h5c, 32'(m));
			rd(8'h5c, 32'(m));
		end
		wr(8'h40, 32'hfffff);
		rd(8'h40, 32'hfffff);
		wr(8'h40, 32'h3);
		wr(8'h50, 32'h1);
		wr(8'h54, 32'h2);
		wr(8'h58, 32'h5);
		wr(8'h68, 32'hffffffff);
		wr(8'h5c, 32'h0);
		wmk <= 4'h8;
		fork
			wr(8'h04, 32'h2);
			for (int n = 1; n <= 60; n++)
			begin
				@(posedge clk);
				hi0 += int'(mk[0] === 1'b1);
				hi1 += int'(mk[1] === 1'b1);
				hi2 += int'(mk[2] === 1'b1);
				if (trig === 1'b1 && ft < 0)
					ft = n;
				if (mk[0] === 1'b1 && f0 < 0)
					f0 = n;
			end
		join
		check(32'(hi0), 32'h1);
		check(32'(f0 - ft >= 3 && f0 - ft <= 5), 32'h1);
		check(32'(hi2), 32'h20);
		check(32'(hi1 >= 28 && hi1 <= 31), 32'h1);
		check(32'(mk[3]), 32'h1);
		wr(8'h00, 32'h66);
		wr(8'h24, 32'h7);
		wr(8'h4c, 32'h2000);
		rd(8'h4c, {12'h0, `ATM_DR_MAX_DEF});
		rd(8'h20, 32'h2);
		wr(8'h44, 32'h800);
		rd(8'h44, 32'h800);
		rd(8'h18, {12'h0, `ATM_DR_MAX_DEF});
		rd(8'h1c, {12'h0, `ATM_DR_MIN_DEF});
	endtask
	task automatic report_and_stop;
		if (mismatches == 0 && cmp_count > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask
	initial
	begin
		#100000;
		mismatches++;
		report_and_stop();
	end
	initial
	begin
		repeat (20) @(posedge clk);
		resetn <= 1'b1;
		@(posedge clk);
		t_reset();
		t_bus_irq();
		t_manual();
		t_ext();
		t_hop();
		t_marker();
		report_and_stop();
	end
endmodule
bind atm_top atm_top_sva #(.DR_MAX(DR_MAX), .DR_MIN(DR_MIN)) atm_top_sva_i (.i_clk(i_clk), .i_resetn(i_resetn),
	.i_wb_cyc(i_wb_cyc), .i_wb_stb(i_wb_stb), .i_wb_we(i_wb_we), .i_wb_adr(i_wb_adr), .i_wb_sel(i_wb_sel),
	.i_wb_dat(i_wb_dat), .o_wb_dat(o_wb_dat), .o_wb_ack(o_wb_ack), .o_trigger(o_trigger),
	.o_current_segment_index(o_current_segment_index));
`default_nettype wire
